// [rst_sleep_pkg.sv]
// Package of constants for the reset pin and sleep control block.
// Assumes a single 100 MHz system clock domain.
`default_nettype none
package rst_sleep_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least low time on the reset pin, in ns (plain default)
  localparam int unsigned RST_MIN_PULSE_NS = 2500;
  localparam int unsigned RST_MIN_CYCLES = (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NARROW_W = 4;
  localparam int unsigned WIDE_W = 8;
  localparam int unsigned NARROW_TOP = 3;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    SLEEP_IDLE = 3'h0,
    SLEEP_ADC_NR = 3'h1,
    SLEEP_PWR_DOWN = 3'h2,
    SLEEP_STANDBY = 3'h3
  } sleep_mode_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_SLEEP = 2'h1
  } pwr_state_t;
endpackage
`default_nettype wire

// [reset_pin_and_sleep_control.sv]
// Reset pin filter, port tri-state during reset and sleep mode gating.
// Assumes reset pin and wake inputs come from outside clk_sys; port
// controls and sleep requests come from logic on clk_sys.
//
// Contract
// - Long low on reset pin resets device
// - Fuse zero turns reset pin into I/O
// - Narrow port tri-stated during any reset
// - Wide port tri-stated during any reset
// - Per-bit pull-up enable on each pin
// - Four software selectable sleep modes
// - Idle stops CPU, peripherals keep running
// - ADC noise reduction keeps only ADC and oscillator
// - Power-down stops all until wake
// - Standby keeps oscillator running only
`default_nettype none
module reset_pin_and_sleep_control #(
  parameter int unsigned RST_MIN_CYCLES = rst_sleep_pkg::RST_MIN_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reset_pin_disable_fuse,
  input wire logic [3:0] narrow_port_pins_in,
  input wire logic [3:0] narrow_port_out,
  input wire logic [3:0] narrow_port_dir,
  input wire logic [3:0] narrow_port_pullup,
  input wire logic [7:0] wide_port_out,
  input wire logic [7:0] wide_port_dir,
  input wire logic [7:0] wide_port_pullup,
  input wire logic [1:0] sleep_mode_sel,
  input wire logic sleep_mode_we,
  input wire logic sleep_exec,
  input wire logic wake_event,
  output logic [3:0] narrow_port_pins_out,
  output logic [3:0] narrow_port_pins_oe,
  output logic [3:0] narrow_port_pins_pu,
  output logic [7:0] wide_port_pins_out,
  output logic [7:0] wide_port_pins_oe,
  output logic [7:0] wide_port_pins_pu,
  output logic pin_reset_q,
  output logic cpu_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic osc_en,
  output logic sleeping
);

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic rpin_s1_q, rpin_s2_q, wake_s1_q, wake_s2_q;
  logic fuse_s1_q, fuse_s2_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rpin_s1_q <= 1'b1;
      rpin_s2_q <= 1'b1;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      fuse_s1_q <= 1'b1;
      fuse_s2_q <= 1'b1;
    end
    else
    begin
      rpin_s1_q <= narrow_port_pins_in[rst_sleep_pkg::NARROW_TOP];
      rpin_s2_q <= rpin_s1_q;
      wake_s1_q <= wake_event;
      wake_s2_q <= wake_s1_q;
      fuse_s1_q <= reset_pin_disable_fuse;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  // --------------------------------------------------------------
  // Reset pin pulse filter
  // --------------------------------------------------------------
  logic [15:0] low_cnt_q, low_cnt_d;
  logic pin_reset_d;
  logic rst_pin_en;
  localparam logic [15:0] MIN_CNT = 16'(RST_MIN_CYCLES);

  // Fuse low: top pin is plain I/O, no reset function
  assign rst_pin_en = fuse_s2_q;

  always_comb
  begin
    low_cnt_d = rst_sleep_pkg::CNT_ZERO;
    pin_reset_d = 1'b0;
    if (rst_pin_en && !rpin_s2_q)
    begin
      if (low_cnt_q >= MIN_CNT)
      begin
        low_cnt_d = low_cnt_q;
        pin_reset_d = 1'b1;
      end
      else
      begin
        low_cnt_d = low_cnt_q + rst_sleep_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cnt_q <= rst_sleep_pkg::CNT_ZERO;
      pin_reset_q <= 1'b0;
    end
    else
    begin
      low_cnt_q <= low_cnt_d;
      pin_reset_q <= pin_reset_d;
    end
  end

  // Pin reset holds the ports released; the unclocked reset clears them below
  logic any_reset;
  assign any_reset = pin_reset_q;

  // --------------------------------------------------------------
  // Port drivers
  // --------------------------------------------------------------
  logic [3:0] n_out_d, n_oe_d, n_pu_d;
  logic [7:0] w_out_d, w_oe_d, w_pu_d;

  always_comb
  begin
    n_out_d = narrow_port_out;
    n_oe_d = narrow_port_dir;
    n_pu_d = narrow_port_pullup & ~narrow_port_dir;
    w_out_d = wide_port_out;
    w_oe_d = wide_port_dir;
    w_pu_d = wide_port_pullup & ~wide_port_dir;
    if (rst_pin_en)
    begin
      // Reset pin never drives; its pull-up still follows narrow_port_pullup and dir
      n_oe_d[rst_sleep_pkg::NARROW_TOP] = 1'b0;
    end
    if (any_reset)
    begin
      n_oe_d = 4'h0;
      n_pu_d = 4'h0;
      w_oe_d = 8'h00;
      w_pu_d = 8'h00;
    end
  end

  // Asynchronous clear gives tri-state with no clock running
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      narrow_port_pins_out <= 4'h0;
      narrow_port_pins_oe <= 4'h0;
      narrow_port_pins_pu <= 4'h0;
      wide_port_pins_out <= 8'h00;
      wide_port_pins_oe <= 8'h00;
      wide_port_pins_pu <= 8'h00;
    end
    else
    begin
      narrow_port_pins_out <= n_out_d;
      narrow_port_pins_oe <= n_oe_d;
      narrow_port_pins_pu <= n_pu_d;
      wide_port_pins_out <= w_out_d;
      wide_port_pins_oe <= w_oe_d;
      wide_port_pins_pu <= w_pu_d;
    end
  end

  // --------------------------------------------------------------
  // Sleep control
  // --------------------------------------------------------------
  rst_sleep_pkg::sleep_mode_t mode_q, mode_d;
  rst_sleep_pkg::pwr_state_t st_q, st_d;
  logic cpu_d, io_d, adc_d, osc_d;

  always_comb
  begin
    mode_d = mode_q;
    st_d = st_q;
    if (sleep_mode_we)
    begin
      mode_d = rst_sleep_pkg::sleep_mode_t'({1'b0, sleep_mode_sel});
    end
    case (st_q)
      rst_sleep_pkg::ST_ACTIVE:
      begin
        if (sleep_exec && !wake_s2_q)
        begin
          st_d = rst_sleep_pkg::ST_SLEEP;
        end
      end
      rst_sleep_pkg::ST_SLEEP:
      begin
        if (wake_s2_q || any_reset)
        begin
          st_d = rst_sleep_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        st_d = rst_sleep_pkg::ST_ACTIVE;
      end
    endcase
    cpu_d = 1'b1;
    io_d = 1'b1;
    adc_d = 1'b1;
    osc_d = 1'b1;
    if (st_d == rst_sleep_pkg::ST_SLEEP)
    begin
      cpu_d = 1'b0;
      case (mode_q)
        rst_sleep_pkg::SLEEP_IDLE:
        begin
          io_d = 1'b1;
        end
        rst_sleep_pkg::SLEEP_ADC_NR:
        begin
          io_d = 1'b0;
        end
        rst_sleep_pkg::SLEEP_PWR_DOWN:
        begin
          io_d = 1'b0;
          adc_d = 1'b0;
          osc_d = 1'b0;
        end
        rst_sleep_pkg::SLEEP_STANDBY:
        begin
          io_d = 1'b0;
          adc_d = 1'b0;
        end
        default:
        begin
          io_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= rst_sleep_pkg::SLEEP_IDLE;
      st_q <= rst_sleep_pkg::ST_ACTIVE;
      cpu_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      osc_en <= 1'b1;
      sleeping <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      st_q <= st_d;
      cpu_clk_en <= cpu_d;
      io_clk_en <= io_d;
      adc_clk_en <= adc_d;
      osc_en <= osc_d;
      sleeping <= (st_d == rst_sleep_pkg::ST_SLEEP);
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_pin_reset_after_low;
    @(posedge clk_sys) disable iff (!rst_n)
    (rst_pin_en && low_cnt_q >= MIN_CNT && !rpin_s2_q) |=> pin_reset_q;
  endproperty
  a_pin_reset_after_low: assert property (p_pin_reset_after_low) else $error("Reset not raised after long low");

  property p_fuse_no_reset;
    @(posedge clk_sys) disable iff (!rst_n)
    (!fuse_s2_q) |=> !pin_reset_q;
  endproperty
  a_fuse_no_reset: assert property (p_fuse_no_reset) else $error("Reset raised with pin disabled");

  property p_narrow_tristate;
    @(posedge clk_sys) disable iff (!rst_n)
    pin_reset_q |=> (narrow_port_pins_oe == 4'h0);
  endproperty
  a_narrow_tristate: assert property (p_narrow_tristate) else $error("Narrow port driven in reset");

  property p_wide_tristate;
    @(posedge clk_sys) disable iff (!rst_n)
    pin_reset_q |=> (wide_port_pins_oe == 8'h00);
  endproperty
  a_wide_tristate: assert property (p_wide_tristate) else $error("Wide port driven in reset");

  property p_pullup_bit;
    @(posedge clk_sys) disable iff (!rst_n)
    !any_reset |=> (wide_port_pins_pu == ($past(wide_port_pullup) & ~$past(wide_port_dir)));
  endproperty
  a_pullup_bit: assert property (p_pullup_bit) else $error("Pull-up bit not applied");

  property p_idle_keeps_io;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && mode_q == rst_sleep_pkg::SLEEP_IDLE) |-> (io_clk_en && !cpu_clk_en);
  endproperty
  a_idle_keeps_io: assert property (p_idle_keeps_io) else $error("Idle gating wrong");

  property p_adc_nr;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && mode_q == rst_sleep_pkg::SLEEP_ADC_NR) |-> (adc_clk_en && !io_clk_en);
  endproperty
  a_adc_nr: assert property (p_adc_nr) else $error("ADC noise mode gating wrong");

  property p_pwr_down;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && mode_q == rst_sleep_pkg::SLEEP_PWR_DOWN) |-> (!osc_en && !adc_clk_en);
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("Power-down gating wrong");

  property p_standby;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && mode_q == rst_sleep_pkg::SLEEP_STANDBY) |-> (osc_en && !io_clk_en);
  endproperty
  a_standby: assert property (p_standby) else $error("Standby gating wrong");

  property p_wake;
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && wake_s2_q) |=> (!sleeping && cpu_clk_en);
  endproperty
  a_wake: assert property (p_wake) else $error("No wake on event");

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    (!sleeping && sleep_exec && !wake_s2_q && !any_reset) |=> (sleeping && !cpu_clk_en);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not entered");

  c_pin_reset: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(pin_reset_q));
  c_pwr_down: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sleeping && mode_q == rst_sleep_pkg::SLEEP_PWR_DOWN);
  c_wake: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(sleeping));

endmodule
`default_nettype wire

// [board_model.sv]
// Board model: reset source and wiring of the narrow port pins.
// Assumes an external pull-up on the reset line and none elsewhere.
`default_nettype none
module board_model (
  input wire logic clk_sys,
  input wire logic [3:0] pins_out,
  input wire logic [3:0] pins_oe,
  input wire logic [3:0] pins_pu,
  output logic [3:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_low = 1'b0;
  logic [3:0] flt_q = 4'h5;
  // --------------
  // Pin levels
  // --------------
  // Undriven pins with no pull-up wander
  always @(posedge clk_sys) flt_q <= ~flt_q;
  always_comb
  begin
    pins_in = (pins_oe & pins_out) | (~pins_oe & (pins_pu | flt_q));
    if (rst_low)
    begin
      pins_in[3] = 1'b0;
    end
    else if (!pins_oe[3])
    begin
      pins_in[3] = 1'b1;
    end
  end
  // Low pulse of n cycles on the reset line
  task automatic pulse(input int n);
    @(posedge clk_sys);
    rst_low <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test_reset_pin_and_sleep_control.sv]
// Bench for the reset pin and sleep control block.
// Assumes board_model on the narrow port and a 100 MHz clk_sys.
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_reset_pin_and_sleep_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MINC = 4;
  logic clk_sys, rst_n, reset_pin_disable_fuse, sleep_mode_we, sleep_exec, wake_event;
  logic pin_reset_q, cpu_clk_en, io_clk_en, adc_clk_en, osc_en, sleeping;
  logic [1:0] sleep_mode_sel;
  logic [3:0] narrow_port_pins_in, narrow_port_out, narrow_port_dir, narrow_port_pullup;
  logic [3:0] narrow_port_pins_out, narrow_port_pins_oe, narrow_port_pins_pu;
  logic [7:0] wide_port_out, wide_port_dir, wide_port_pullup;
  logic [7:0] wide_port_pins_out, wide_port_pins_oe, wide_port_pins_pu;
  int n_fail = 0;
  int n_tests = 0;
  // --------------
  // Harness and scenarios
  // --------------
  reset_pin_and_sleep_control #(.RST_MIN_CYCLES(MINC)) uut (
    .clk_sys, .rst_n, .reset_pin_disable_fuse, .narrow_port_pins_in, .narrow_port_out,
    .narrow_port_dir, .narrow_port_pullup, .wide_port_out, .wide_port_dir, .wide_port_pullup,
    .sleep_mode_sel, .sleep_mode_we, .sleep_exec, .wake_event, .narrow_port_pins_out,
    .narrow_port_pins_oe, .narrow_port_pins_pu, .wide_port_pins_out, .wide_port_pins_oe,
    .wide_port_pins_pu, .pin_reset_q, .cpu_clk_en, .io_clk_en, .adc_clk_en, .osc_en, .sleeping
  );
  board_model brd (
    .clk_sys,
    .pins_out(narrow_port_pins_out),
    .pins_oe(narrow_port_pins_oe),
    .pins_pu(narrow_port_pins_pu),
    .pins_in(narrow_port_pins_in)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait on sleeping or pin_reset_q
  task automatic wait_flag(input bit slp, input logic v);
    int i;
    #1;
    for (i = 0; i < 40 && (slp ? sleeping : pin_reset_q) !== v; i++)
    begin
      tick(1);
    end
    if (i == 40)
    begin
      n_fail++;
      $display("[ERR] wait_flag exp %h got %h", v, slp ? sleeping : pin_reset_q);
      end_sim();
    end
  endtask
  task automatic t_ports(input logic f);
    @(posedge clk_sys);
    reset_pin_disable_fuse <= f;
    narrow_port_out <= 4'hf;
    narrow_port_dir <= 4'hc;
    narrow_port_pullup <= 4'h5;
    wide_port_dir <= 8'ha5;
    wide_port_out <= 8'h3c;
    wide_port_pullup <= 8'hff;
    tick(5);
    `CHK("n_oe", {~f, 3'h4}, narrow_port_pins_oe)
    `CHK("n_pu", 4'h1, narrow_port_pins_pu)
    `CHK("w_oe", 8'ha5, wide_port_pins_oe)
    `CHK("w_pu", 8'h5a, wide_port_pins_pu)
    `CHK("n_out", 4'hf, narrow_port_pins_out)
    `CHK("w_out", 8'h3c, wide_port_pins_out)
  endtask
  task automatic t_pin_rst();
    t_ports(1'b1);
    brd.pulse(MINC - 1);
    tick(MINC);
    `CHK("short", 1'b0, pin_reset_q)
    fork
      brd.pulse(MINC + 10);
      begin
        wait_flag(1'b0, 1'b1);
        tick(1);
        `CHK("n_oe rst", 4'h0, narrow_port_pins_oe)
        `CHK("w_oe rst", 8'h00, wide_port_pins_oe)
        `CHK("w_pu rst", 8'h00, wide_port_pins_pu)
        `CHK("n_pu rst", 4'h0, narrow_port_pins_pu)
      end
    join
    wait_flag(1'b0, 1'b0);
    tick(1);
    `CHK("w_oe back", 8'ha5, wide_port_pins_oe)
    t_ports(1'b0);
    fork
      brd.pulse(MINC + 10);
      begin
        tick(MINC + 8);
        `CHK("fuse off", 1'b0, pin_reset_q)
      end
    join
  endtask
  task automatic t_sleep(input logic [1:0] m, input logic [3:0] e);
    @(posedge clk_sys);
    sleep_mode_sel <= m;
    sleep_mode_we <= 1'b1;
    @(posedge clk_sys);
    sleep_mode_we <= 1'b0;
    sleep_exec <= 1'b1;
    #1;
    `CHK("early", 1'b0, sleeping)
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    tick(3);
    `CHK("asleep", 1'b1, sleeping)
    `CHK("gates", e, {cpu_clk_en, io_clk_en, adc_clk_en, osc_en})
    @(posedge clk_sys);
    wake_event <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wake_event <= 1'b0;
    wait_flag(1'b1, 1'b0);
    `CHK("awake", 4'hf, {cpu_clk_en, io_clk_en, adc_clk_en, osc_en})
  endtask
  task automatic t_async();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #2;
    `CHK("n_oe async", 4'h0, narrow_port_pins_oe)
    `CHK("w_oe async", 8'h00, wide_port_pins_oe)
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(5);
    `CHK("w_oe after", 8'ha5, wide_port_pins_oe)
  endtask
  initial
  begin
    rst_n = 1'b0;
    reset_pin_disable_fuse = 1'b1;
    {sleep_mode_we, sleep_exec, wake_event, sleep_mode_sel} = 5'h00;
    {narrow_port_out, narrow_port_dir, narrow_port_pullup} = 12'h000;
    {wide_port_out, wide_port_dir, wide_port_pullup} = 24'h000000;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_ports(1'b1);
    t_pin_rst();
    t_sleep(2'h0, 4'h7);
    t_sleep(2'h1, 4'h3);
    t_sleep(2'h2, 4'h0);
    t_sleep(2'h3, 4'h1);
    t_async();
    end_sim();
  end
endmodule
`default_nettype wire
